/* File: rtl/cid_pkg.sv */
// Purpose: Constants for the chip identity register bank
// Assumes: APB slave with 32-bit data, word aligned registers
// Notes: Identity field values are wiring parameters of the top module
package cid_pkg;
  // Register byte offsets
  localparam logic [11:0] CID_OFF_MAIN = 12'h000;
  localparam logic [11:0] CID_OFF_EXT = 12'h004;
  // Main word field positions
  localparam int CID_EXT_BIT = 31;
  localparam int CID_TYP_LSB = 28;
  localparam int CID_FAM_LSB = 20;
  localparam int CID_RAM_LSB = 16;
  localparam int CID_SZ2_LSB = 12;
  localparam int CID_SZ1_LSB = 8;
  localparam int CID_PROC_LSB = 5;
  localparam int CID_REV_LSB = 0;
  // Program memory type codes
  localparam logic [2:0] CID_TYP_ROM = 3'h0;
  localparam logic [2:0] CID_TYP_ROMLESS = 3'h1;
  localparam logic [2:0] CID_TYP_FLASH = 3'h2;
  localparam logic [2:0] CID_TYP_ROM_FLASH = 3'h3;
  localparam logic [2:0] CID_TYP_SRAM = 3'h4;
  // Reset values
  localparam logic [31:0] CID_RDATA_RST = 32'h0000_0000;
  // Bus answer states
  typedef enum logic [0:0] {
    CID_IDLE = 1'b0,
    CID_DONE = 1'b1
  } cid_state_t;
endpackage

/* File: rtl/cid_regs.sv */
// Purpose: Read-only chip identity words behind an APB slave
// Assumes: Single clock pclk, asynchronous active-low reset presetn
// Notes: One wait state on every access; writes have no effect
//
// How it works
// - The main identity word sits at offset 0 and the extension word at offset 4, both read-only.
// - Both words are fixed by wiring parameters and no bus access changes them.
// - The extension word reads zero whenever the extension flag is clear.
// - Bit 31 of the main word is the extension flag.
// - Bits 30 to 28 give the program memory type code.
// - With type ROM plus flash, the first size field is ROM and the second is flash.
// - Bits 11 to 8 give the first program memory size code; reserved codes are refused.
// - Bits 15 to 12 give the second program memory size with the same code table.
// - Bits 19 to 16 give the internal RAM size code.
// - Bits 27 to 20 hold the eight-bit family code.
// - Bits 7 to 5 hold the processor code.
// - Bits 4 to 0 hold the silicon revision.
module cid_regs
  import cid_pkg::*;
#(
  parameter logic second_word_present = 1'b0,
  parameter logic [2:0] program_memory_type = CID_TYP_ROM_FLASH,
  parameter logic [3:0] program_memory_size_first = 4'h2,
  parameter logic [3:0] program_memory_size_second = 4'h9,
  parameter logic [3:0] internal_ram_size = 4'hb,
  // Family, processor, revision and extension values are arbitrary
  parameter logic [7:0] family_code = 8'h5a,
  parameter logic [2:0] processor_code = 3'h3,
  parameter logic [4:0] revision = 5'h01,
  parameter logic [31:0] extension_value = 32'h1234_5678
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  // Size code check shared by both size fields
  function automatic logic cid_size_ok(input logic [3:0] code);
    unique case (code)
      4'h4, 4'h6, 4'h8, 4'hb, 4'hd, 4'hf: cid_size_ok = 1'b0;
      default: cid_size_ok = 1'b1;
    endcase
  endfunction

  // Wiring checks on the identity fields
  initial begin
    if (!cid_size_ok(program_memory_size_first)) begin
      $error("first size code reserved");
    end
    if (!cid_size_ok(program_memory_size_second)) begin
      $error("second size code reserved");
    end
    if (program_memory_type > CID_TYP_SRAM) begin
      $error("memory type code reserved");
    end
  end

  // Packed main word and gated extension word
  logic [31:0] main_word;
  logic [31:0] ext_word;
  assign main_word = {second_word_present,
                      program_memory_type,
                      family_code,
                      internal_ram_size,
                      program_memory_size_second,
                      program_memory_size_first,
                      processor_code,
                      revision};
  assign ext_word = second_word_present ? extension_value : 32'h0000_0000;

  // Read decode by full byte address
  function automatic logic [31:0] cid_read(input logic [11:0] addr,
                                           input logic [31:0] mw,
                                           input logic [31:0] ew);
    unique case (addr)
      CID_OFF_MAIN: cid_read = mw;
      CID_OFF_EXT: cid_read = ew;
      default: cid_read = 32'h0000_0000;
    endcase
  endfunction

  cid_state_t state_r, state_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;
  logic mapped;

  assign mapped = (paddr == CID_OFF_MAIN) || (paddr == CID_OFF_EXT);

  // Next answer: one wait state, writes dropped
  always_comb begin
    state_nxt = state_r;
    prdata_nxt = prdata_r;
    pready_nxt = 1'b0;
    pslverr_nxt = 1'b0;
    unique case (state_r)
      CID_IDLE: begin
        if (psel && penable) begin
          state_nxt = CID_DONE;
          pready_nxt = 1'b1;
          pslverr_nxt = !mapped;
          prdata_nxt = pwrite ? CID_RDATA_RST : cid_read(paddr, main_word, ext_word);
        end
      end
      CID_DONE: begin
        state_nxt = CID_IDLE;
        prdata_nxt = CID_RDATA_RST;
      end
    endcase
  end

  // Answer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= CID_IDLE;
      prdata_r <= CID_RDATA_RST;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;

  // Unused write inputs
  logic unused_w;
  assign unused_w = ^{pwdata, pstrb};

  // Access with one wait state
  sequence cid_access_s;
    psel && penable && !pready;
  endsequence

  read_main_a: assert property (@(posedge pclk) disable iff (!presetn)
    cid_access_s and !pwrite && paddr == CID_OFF_MAIN |=> pready && prdata == main_word)
    else $error("main word read wrong");
  read_ext_a: assert property (@(posedge pclk) disable iff (!presetn)
    cid_access_s and !pwrite && paddr == CID_OFF_EXT && !second_word_present |=>
      pready && prdata == 32'h0000_0000)
    else $error("extension not zero with flag clear");
  ext_match_a: assert property (@(posedge pclk) disable iff (!presetn)
    cid_access_s and !pwrite && paddr == CID_OFF_EXT && second_word_present |=>
      prdata == extension_value)
    else $error("extension word wrong");
  wait_state_a: assert property (@(posedge pclk) disable iff (!presetn)
    cid_access_s |=> pready ##1 !pready)
    else $error("access latency wrong");
  write_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
    cid_access_s and pwrite |=> prdata == 32'h0000_0000)
    else $error("write returned data");
  fields_fixed_a: assert property (@(posedge pclk) disable iff (!presetn)
    $stable(main_word) && $stable(ext_word))
    else $error("identity changed");
  rev_field_a: assert property (@(posedge pclk) disable iff (!presetn)
    main_word[4:0] == revision && main_word[7:5] == processor_code)
    else $error("revision or processor field wrong");
  fam_field_a: assert property (@(posedge pclk) disable iff (!presetn)
    main_word[27:20] == family_code && main_word[30:28] == program_memory_type)
    else $error("family or type field wrong");
  size_field_a: assert property (@(posedge pclk) disable iff (!presetn)
    main_word[11:8] == program_memory_size_first &&
    main_word[15:12] == program_memory_size_second &&
    main_word[19:16] == internal_ram_size)
    else $error("size fields wrong");
  unmapped_a: assert property (@(posedge pclk) disable iff (!presetn)
    cid_access_s and !mapped |=> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped answer wrong");

  // Answer cycle of a transfer
  sequence cid_answer_s;
    psel && penable && pready;
  endsequence

  // First access cycle of a write
  sequence cid_write_s;
    psel && penable && !pready && pwrite;
  endsequence

  // First access cycle of a read of the main word
  sequence cid_read_main_s;
    psel && penable && !pready && !pwrite && (paddr == CID_OFF_MAIN);
  endsequence

  // Answer lasts exactly one cycle
  ready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("pready longer than one cycle");

  // Answer only follows a first access cycle
  ready_cause_a: assert property (@(posedge pclk) disable iff (!presetn)
    pready |-> $past(psel) && $past(penable) && !$past(pready))
    else $error("pready without request");

  // Read data is zero outside the answer cycle
  idle_data_a: assert property (@(posedge pclk) disable iff (!presetn)
    !pready |-> prdata == 32'h0000_0000)
    else $error("prdata not zero when idle");

  // Error flag only rides on an answer
  err_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready)
    else $error("pslverr without pready");

  // Both mapped words answer without error
  mapped_ok_a: assert property (@(posedge pclk) disable iff (!presetn)
    cid_access_s and mapped |=> pready && !pslverr)
    else $error("mapped access flagged");

  // Unaligned addresses are not mapped
  unaligned_a: assert property (@(posedge pclk) disable iff (!presetn)
    cid_access_s and paddr[1:0] != 2'b00 |=> pslverr)
    else $error("unaligned access not flagged");

  // Addresses past the extension word are not mapped
  high_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
    cid_access_s and paddr[11:3] != 9'h000 |=> pslverr)
    else $error("high address not flagged");

  // Write to the main word is ignored cleanly
  write_main_a: assert property (@(posedge pclk) disable iff (!presetn)
    cid_write_s and paddr == CID_OFF_MAIN |=> pready && !pslverr && prdata == 32'h0000_0000)
    else $error("main word write answer wrong");

  // Write to the extension word is ignored cleanly
  write_ext_a: assert property (@(posedge pclk) disable iff (!presetn)
    cid_write_s and paddr == CID_OFF_EXT |=> pready && !pslverr && prdata == 32'h0000_0000)
    else $error("extension write answer wrong");

  // Answer returns the slave to idle
  answer_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
    cid_answer_s |=> state_r == CID_IDLE && !pready)
    else $error("slave not idle after answer");

  // No answer without a selected request
  no_request_a: assert property (@(posedge pclk) disable iff (!presetn)
    !psel |=> !pready)
    else $error("pready while not selected");

  // Setup cycle alone never answers
  setup_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable |=> !pready)
    else $error("pready after setup cycle");

  // Extension flag seen on the bus
  flag_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    cid_read_main_s |=> prdata[CID_EXT_BIT] == second_word_present)
    else $error("flag read wrong");

  // Memory type seen on the bus
  type_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    cid_read_main_s |=> prdata[30:28] == program_memory_type)
    else $error("type read wrong");

  // Family code seen on the bus
  fam_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    cid_read_main_s |=> prdata[27:20] == family_code)
    else $error("family read wrong");

  // RAM size seen on the bus
  ram_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    cid_read_main_s |=> prdata[19:16] == internal_ram_size)
    else $error("ram size read wrong");

  // Second program size seen on the bus
  size2_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    cid_read_main_s |=> prdata[15:12] == program_memory_size_second)
    else $error("second size read wrong");

  // First program size seen on the bus
  size1_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    cid_read_main_s |=> prdata[11:8] == program_memory_size_first)
    else $error("first size read wrong");

  // Processor code seen on the bus
  proc_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    cid_read_main_s |=> prdata[7:5] == processor_code)
    else $error("processor read wrong");

  // Revision seen on the bus
  rev_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    cid_read_main_s |=> prdata[4:0] == revision)
    else $error("revision read wrong");

  // Memory type code is one of the defined ones
  type_legal_a: assert property (@(posedge pclk) disable iff (!presetn)
    main_word[30:28] <= CID_TYP_SRAM)
    else $error("type code reserved");

  // Neither size field holds a reserved code
  size_legal_a: assert property (@(posedge pclk) disable iff (!presetn)
    cid_size_ok(main_word[11:8]) && cid_size_ok(main_word[15:12]))
    else $error("size code reserved");

  // With ROM plus flash the first size field is the ROM size
  rom_flash_a: assert property (@(posedge pclk) disable iff (!presetn)
    main_word[30:28] == CID_TYP_ROM_FLASH |-> main_word[11:8] == program_memory_size_first)
    else $error("rom size field wrong");

  // Flag clear hides the extension value
  ext_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    !main_word[CID_EXT_BIT] |-> ext_word == 32'h0000_0000)
    else $error("extension visible with flag clear");

  // Flag set shows the wired extension value
  ext_value_a: assert property (@(posedge pclk) disable iff (!presetn)
    main_word[CID_EXT_BIT] |-> ext_word == extension_value)
    else $error("extension value wrong");

endmodule // cid_regs

/* File: bench/test_cid_regs.sv */
// Purpose: APB read and write checks of the chip identity words
// Assumes: One wait state per access, pslverr high on unmapped addresses
// Notes: Two instances, one with the extension flag clear and one with it set
module test_cid_regs import cid_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata, prdata_x, rd0, rd1;
  logic pready, pready_x, pslverr, pslverr_x;
  logic [1:0] er;
  int num_errors = 0;
  int total_checks = 0;
  // Expected words packed field by field
  localparam logic [31:0] MAIN0 = {1'b0, 3'h3, 8'h5a, 4'hb, 4'h9, 4'h2, 3'h3, 5'h01};
  localparam logic [31:0] MAIN1 = {1'b1, 3'h2, 8'h3c, 4'hb, 4'h9, 4'h2, 3'h3, 5'h1f};
  localparam logic [31:0] EXT1 = 32'ha5c3_0f1e;
  // 250 MHz clock
  always #2 pclk = ~pclk;
  // Flag clear, default extension value must stay hidden
  cid_regs uut (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr);
  // Flag set, other type and family, top revision
  cid_regs #(.second_word_present(1'b1), .program_memory_type(3'h2),
    .family_code(8'h3c), .revision(5'h1f), .extension_value(EXT1)) uut_x (.pclk,
    .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata(prdata_x),
    .pready(pready_x), .pslverr(pslverr_x));
  // Counts and verdict
  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Compare one 32-bit result
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  // One APB transfer to both instances, then result checks
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] e0,
    input logic [31:0] e1, input logic [1:0] ee);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= 32'hffff_ffff;
    pstrb <= 4'hf;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      num_errors++;
      stop_test();
    end
    chk("latency", 32'd2, 32'(n));
    rd0 = prdata;
    rd1 = prdata_x;
    er = {pslverr_x, pslverr};
    psel <= 1'b0;
    penable <= 1'b0;
    chk("prdata", e0, rd0);
    chk("prdata_x", e1, rd1);
    chk("pslverr", {30'h0, ee}, {30'h0, er});
    @(posedge pclk);
  endtask
  // Main sequence
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    xfer(1'b0, CID_OFF_MAIN, MAIN0, MAIN1, 2'b00);
    xfer(1'b0, CID_OFF_MAIN, MAIN0, MAIN1, 2'b00);
    xfer(1'b0, CID_OFF_EXT, 32'h0, EXT1, 2'b00);
    $display("test reads done");
    xfer(1'b1, CID_OFF_MAIN, 32'h0, 32'h0, 2'b00);
    xfer(1'b1, CID_OFF_EXT, 32'h0, 32'h0, 2'b00);
    xfer(1'b0, CID_OFF_MAIN, MAIN0, MAIN1, 2'b00);
    xfer(1'b0, CID_OFF_EXT, 32'h0, EXT1, 2'b00);
    $display("test writes done");
    xfer(1'b0, 12'h008, 32'h0, 32'h0, 2'b11);
    xfer(1'b0, 12'h002, 32'h0, 32'h0, 2'b11);
    xfer(1'b1, 12'hffc, 32'h0, 32'h0, 2'b11);
    $display("test unmapped done");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("prdata in reset", 32'h0, prdata);
    chk("pready in reset", 32'h0, {31'h0, pready});
    chk("pslverr in reset", 32'h0, {31'h0, pslverr});
    presetn <= 1'b1;
    @(posedge pclk);
    xfer(1'b0, CID_OFF_MAIN, MAIN0, MAIN1, 2'b00);
    xfer(1'b0, CID_OFF_EXT, 32'h0, EXT1, 2'b00);
    $display("test reset done");
    stop_test();
  end
endmodule // test_cid_regs
